// >>> hw/mip_defs.vh
// Purpose: Shared constants of the motion-interrupt parameter bank.
// Assumes: Included by bare name before any module that uses it.
// Notes:   Register indexes are word indexes; byte address is four times the index.
`ifndef MIP_DEFS_VH
`define MIP_DEFS_VH
// Register indexes.
`define MIP_IDX_HYST    6'h24
`define MIP_IDX_HDLY    6'h25
`define MIP_IDX_HTHR    6'h26
`define MIP_IDX_DUR     6'h27
`define MIP_IDX_ATHR    6'h28
`define MIP_IDX_STHR    6'h29
`define MIP_IDX_TAP     6'h2A
`define MIP_IDX_CTRL    6'h10
`define MIP_IDX_STAT    6'h11
// Reset values.
`define MIP_RST_HYST    8'h81
`define MIP_RST_HDLY    8'h0F
`define MIP_RST_HTHR    8'hC0
`define MIP_RST_DUR     8'h00
`define MIP_RST_ATHR    8'h14
`define MIP_RST_STHR    8'h14
`define MIP_RST_TAP     8'h04
`define MIP_RST_CTRL    8'h00
// Writable-bit masks; reserved positions store and read zero.
`define MIP_MSK_HYST    8'hC7
`define MIP_MSK_TAP     8'hC7
`define MIP_MSK_CTRL    8'h07
// Field positions.
`define MIP_F_HHYST     7:6
`define MIP_F_LMODE     2
`define MIP_F_LHYST     1:0
`define MIP_F_SDUR      7:2
`define MIP_F_SCNT      3:2
`define MIP_F_ADUR      1:0
`define MIP_F_QUIET     7
`define MIP_F_SHOCK     6
`define MIP_F_TDUR      2:0
`define MIP_F_RANGE     1:0
`define MIP_F_SSEL      2
// Scale shifts in units of 1/256 g (3.90625 mg).
`define MIP_SH_SLOPE    3'h0
`define MIP_SH_HTHR     3'h1
`define MIP_SH_HYST     3'h5
// Timing figures.
`define MIP_HDLY_STEP_MS 10'h002
`define MIP_QUIET0_MS   7'h1E
`define MIP_QUIET1_MS   7'h14
`define MIP_SHOCK0_MS   7'h32
`define MIP_SHOCK1_MS   7'h4B
`define MIP_NM_OFS1     9'h014
`define MIP_NM_OFS2     9'h058
`define MIP_CLK_NS      8
`define MIP_SEC_NS      1000000000
// Bus response codes.
`define MIP_RESP_OKAY   2'h0
`define MIP_RESP_SLVERR 2'h2
`endif

// >>> hw/mip_scale.v
// Purpose: Range-scaled thresholds and hysteresis for the motion detectors.
// Assumes: Same clock as the register bank; fields are stable register outputs.
// Notes:   Results are in units of 1/256 g so every step is a power of two.
`include "mip_defs.vh"
module mip_scale (
  // Clock and reset.
  input  wire        clk,
  input  wire        rstn,
  // Configuration fields.
  input  wire [1:0]  range_sel,
  input  wire [1:0]  highg_hysteresis,
  input  wire [1:0]  lowg_hysteresis,
  input  wire [7:0]  highg_threshold,
  input  wire [7:0]  anymotion_threshold,
  input  wire [7:0]  stillness_threshold,
  // Scaled results.
  output reg  [11:0] highg_thresh_out,
  output reg  [11:0] highg_hyst_out,
  output reg  [11:0] lowg_hyst_out,
  output reg  [11:0] any_thresh_out,
  output reg  [11:0] still_thresh_out
);
  // Field times a step of 2^base units, doubled for each larger range.
  function [11:0] scale;
    input [7:0] field;
    input [2:0] base;
    input [1:0] rng;
    reg   [19:0] wide;
    begin
      wide  = {12'h000, field} << ({1'b0, base} + {2'b00, rng});
      scale = wide[11:0];
    end
  endfunction

  // Registered so the downstream comparators see flip-flop outputs; a range change
  // lands one cycle later, well before the next sample strobe.
  always @(posedge clk) begin
    if (!rstn) begin
      highg_thresh_out <= 12'h000;
      highg_hyst_out   <= 12'h000;
      lowg_hyst_out    <= 12'h000;
      any_thresh_out   <= 12'h000;
      still_thresh_out <= 12'h000;
    end else begin
      highg_hyst_out   <= scale({6'h00, highg_hysteresis}, `MIP_SH_HYST, range_sel);  // see RULE1 RULE15
      lowg_hyst_out    <= scale({6'h00, lowg_hysteresis}, `MIP_SH_HYST, 2'h0);       // see RULE3
      highg_thresh_out <= scale(highg_threshold, `MIP_SH_HTHR, range_sel);          // see RULE5 RULE15
      any_thresh_out   <= scale(anymotion_threshold, `MIP_SH_SLOPE, range_sel);     // see RULE9
      still_thresh_out <= scale(stillness_threshold, `MIP_SH_SLOPE, range_sel);     // see RULE10
    end
  end
endmodule

// >>> hw/mip_motion.v
// Purpose: Slope detector: consecutive-sample count or quiet-time trigger.
// Assumes: Sample strobe and one-second tick are single-cycle pulses on clk.
// Notes:   A strobe above threshold restarts the quiet timer even if a tick coincides.
module mip_motion (
  // Clock and reset.
  input  wire        clk,
  input  wire        rstn,
  // Sample path.
  input  wire        sample_strobe,
  input  wire [11:0] slope_mag,
  input  wire [11:0] thresh,
  // Mode and timing.
  input  wire [2:0]  need_cnt,
  input  wire        timed_mode,
  input  wire [8:0]  hold_sec,
  input  wire        sec_tick,
  // Results.
  output reg         trig,
  output reg         active
);
  wire       above = slope_mag > thresh;  // Sample exceeds the threshold.
  reg  [2:0] run_reg;                     // Consecutive samples above threshold.
  reg  [8:0] secs_reg;                    // Whole seconds without a sample above threshold.

  // Count or time the slope samples and pulse once when the condition is reached.
  always @(posedge clk) begin
    if (!rstn) begin
      run_reg  <= 3'h0;
      secs_reg <= 9'h000;
      trig     <= 1'b0;
      active   <= 1'b0;
    end else begin
      trig <= 1'b0;
      if (!timed_mode) begin
        // Count mode: trigger on the n-th consecutive sample above threshold.
        if (sample_strobe) begin
          if (above) begin
            if (run_reg != need_cnt) begin
              run_reg <= run_reg + 3'h1;
            end
            if (run_reg + 3'h1 == need_cnt) begin  // see RULE6 RULE8
              trig   <= 1'b1;
              active <= 1'b1;
            end
          end else begin
            run_reg <= 3'h0;
            active  <= 1'b0;
          end
        end
      end else begin
        // Timed mode: any sample above threshold restarts the quiet time.
        if (sample_strobe && above) begin
          secs_reg <= 9'h000;
          active   <= 1'b0;
        end else if (sec_tick && secs_reg != hold_sec) begin
          secs_reg <= secs_reg + 9'h001;
          if (secs_reg + 9'h001 == hold_sec) begin  // see RULE7
            trig   <= 1'b1;
            active <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// >>> hw/mip_param_regs.v
// Purpose: AXI4-Lite register bank steering the motion-interrupt engines.
// Assumes: Slope samples come from logic on CLK, so they need no synchroniser.
// Notes:   Thresholds leave in units of 1/256 g; times leave in ms or seconds.
//
// What this block does
// RULE1: High-g hysteresis step 125 mg, doubling per range.
// RULE2: Low-g mode bit selects per-axis or summed evaluation.
// RULE3: Low-g hysteresis step 125 mg in every range.
// RULE4: High-g delay is (field plus one) times 2 ms.
// RULE5: High-g threshold step 7.81 mg, doubling per range.
// RULE6: Slow-motion needs (duration low bits plus one) samples.
// RULE7: No-motion waits a coded number of seconds.
// RULE8: Any-motion needs (count plus one) consecutive samples.
// RULE9: Any-motion threshold step 3.91 mg, doubling per range.
// RULE10: Stillness threshold scaled like the any-motion threshold.
// RULE11: Tap quiet is 30 ms or 20 ms.
// RULE12: Tap shock is 50 ms or 75 ms.
// RULE13: Double-tap window coded from 50 to 700 ms.
// RULE14: Software writes zero to reserved bits.
// RULE15: Scaling follows the currently selected acceleration range.
`include "mip_defs.vh"
module mip_param_regs #(
  parameter         ADDR_W     = 8,
  parameter [31:0]  SEC_CYCLES = `MIP_SEC_NS / `MIP_CLK_NS
) (
  // Clock and reset.
  input  wire              CLK,
  input  wire              RSTN,
  // AXI4-Lite write address and data.
  input  wire [ADDR_W-1:0] AWADDR,
  input  wire              AWVALID,
  output wire              AWREADY,
  input  wire [31:0]       WDATA,
  input  wire [3:0]        WSTRB,
  input  wire              WVALID,
  output wire              WREADY,
  // AXI4-Lite write response.
  output reg  [1:0]        BRESP,
  output reg               BVALID,
  input  wire              BREADY,
  // AXI4-Lite read.
  input  wire [ADDR_W-1:0] ARADDR,
  input  wire              ARVALID,
  output wire              ARREADY,
  output reg  [31:0]       RDATA,
  output reg  [1:0]        RRESP,
  output reg               RVALID,
  input  wire              RREADY,
  // Slope sample stream.
  input  wire              SAMPLE_STROBE,
  input  wire [11:0]       SLOPE_MAG,
  // High-g and low-g settings.
  output wire [11:0]       HIGHG_THRESH,
  output wire [11:0]       HIGHG_HYST,
  output reg  [9:0]        HIGHG_DELAY_MS,
  output wire [11:0]       LOWG_HYST,
  output reg               LOWG_SUM_MODE,
  // Motion settings and events.
  output wire [11:0]       ANYMOTION_THRESH,
  output wire [11:0]       STILLNESS_THRESH,
  output reg  [8:0]        NOMOTION_SEC,
  output wire              ANYMOTION_TRIG,
  output wire              STILLNESS_TRIG,
  // Tap timing.
  output reg  [6:0]        TAP_QUIET_MS,
  output reg  [6:0]        TAP_SHOCK_MS,
  output reg  [9:0]        DTAP_WINDOW_MS
);
  // Configuration registers.
  reg  [7:0]        motion_hysteresis_cfg_reg;    // High-g and low-g hysteresis, low-g mode.
  reg  [7:0]        highg_delay_cfg_reg;          // High-g trigger delay.
  reg  [7:0]        highg_threshold_cfg_reg;      // High-g threshold.
  reg  [7:0]        anymotion_duration_cfg_reg;   // Stillness duration and any-motion count.
  reg  [7:0]        anymotion_threshold_cfg_reg;  // Any-motion threshold.
  reg  [7:0]        stillness_threshold_cfg_reg;  // Stillness threshold.
  reg  [7:0]        knock_timing_cfg_reg;         // Tap quiet, shock and window.
  reg  [7:0]        ctrl_reg;                     // Range select and stillness mode.
  // Write channel holding state.
  reg               aw_full_reg;                  // Write address taken, waiting for data.
  reg  [ADDR_W-1:0] aw_addr_reg;                  // Held write address.
  reg               w_full_reg;                   // Write data taken, waiting for address.
  reg  [7:0]        w_data_reg;                   // Held low data byte.
  reg               w_strb_reg;                   // Held lane-0 strobe.
  // One-second divider.
  reg  [31:0]       sec_cnt_reg;                  // Cycle count within the current second.
  reg               sec_tick_reg;                 // One-cycle pulse per second.
  // Detector levels for the status register.
  wire              any_active;                   // Any-motion condition holds.
  wire              still_active;                 // Stillness condition holds.

  // Word index of a byte address; the two low bits are ignored for aligned words.
  function [5:0] word_idx;
    input [ADDR_W-1:0] addr;
    begin
      word_idx = addr[7:2];
    end
  endfunction

  // True when the index names a register of this bank.
  function mapped;
    input [5:0] idx;
    begin
      mapped = (idx >= `MIP_IDX_HYST && idx <= `MIP_IDX_TAP) ||
               idx == `MIP_IDX_CTRL || idx == `MIP_IDX_STAT;
    end
  endfunction

  // Double-tap second-shock window in ms.
  function [9:0] tap_window;
    input [2:0] code;
    begin
      case (code)
        3'h0:    tap_window = 10'h032;
        3'h1:    tap_window = 10'h064;
        3'h2:    tap_window = 10'h096;
        3'h3:    tap_window = 10'h0C8;
        3'h4:    tap_window = 10'h0FA;
        3'h5:    tap_window = 10'h177;
        3'h6:    tap_window = 10'h1F4;
        default: tap_window = 10'h2BC;
      endcase
    end
  endfunction

  // No-motion quiet time in seconds from the six-bit duration field.
  function [8:0] nomo_sec;
    input [5:0] dur;
    begin
      if (dur[5]) begin
        nomo_sec = {1'b0, dur[4:0], 3'h0} + `MIP_NM_OFS2;
      end else if (dur[4]) begin
        nomo_sec = {3'h0, dur[3:0], 2'h0} + `MIP_NM_OFS1;
      end else begin
        nomo_sec = {5'h00, dur[3:0]} + 9'h001;
      end
    end
  endfunction

  // A write request is accepted only while the write response is not pending; a read only while no read data is pending.
  assign AWREADY = !aw_full_reg && !BVALID;
  assign WREADY  = !w_full_reg && !BVALID;
  assign ARREADY = !RVALID;

  // Address and data may arrive in either order or together.
  wire              aw_take = AWVALID && AWREADY;
  wire              w_take  = WVALID && WREADY;
  wire              aw_have = aw_full_reg || aw_take;
  wire              w_have  = w_full_reg || w_take;
  wire              wr_fire = aw_have && w_have;
  wire [ADDR_W-1:0] wr_addr = aw_full_reg ? aw_addr_reg : AWADDR;
  wire [7:0]        wr_data = w_full_reg ? w_data_reg : WDATA[7:0];
  wire              wr_lane = w_full_reg ? w_strb_reg : WSTRB[0];
  wire [5:0]        wr_idx  = word_idx(wr_addr);

  // Hold whichever half of a write arrives first until the other joins it.
  always @(posedge CLK) begin
    if (!RSTN) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_full_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_full_reg <= 1'b1;
          aw_addr_reg <= AWADDR;
        end
        if (w_take) begin
          w_full_reg <= 1'b1;
          w_data_reg <= WDATA[7:0];
          w_strb_reg <= WSTRB[0];
        end
      end
    end
  end

  // Register writes; reserved bits are masked so they always read back as zero.
  always @(posedge CLK) begin
    if (!RSTN) begin
      motion_hysteresis_cfg_reg   <= `MIP_RST_HYST;
      highg_delay_cfg_reg         <= `MIP_RST_HDLY;
      highg_threshold_cfg_reg     <= `MIP_RST_HTHR;
      anymotion_duration_cfg_reg  <= `MIP_RST_DUR;
      anymotion_threshold_cfg_reg <= `MIP_RST_ATHR;
      stillness_threshold_cfg_reg <= `MIP_RST_STHR;
      knock_timing_cfg_reg        <= `MIP_RST_TAP;
      ctrl_reg                    <= `MIP_RST_CTRL;
    end else if (wr_fire && wr_lane) begin
      case (wr_idx)
        `MIP_IDX_HYST: motion_hysteresis_cfg_reg   <= wr_data & `MIP_MSK_HYST;  // see RULE14
        `MIP_IDX_HDLY: highg_delay_cfg_reg         <= wr_data;
        `MIP_IDX_HTHR: highg_threshold_cfg_reg     <= wr_data;
        `MIP_IDX_DUR:  anymotion_duration_cfg_reg  <= wr_data;
        `MIP_IDX_ATHR: anymotion_threshold_cfg_reg <= wr_data;
        `MIP_IDX_STHR: stillness_threshold_cfg_reg <= wr_data;
        `MIP_IDX_TAP:  knock_timing_cfg_reg        <= wr_data & `MIP_MSK_TAP;   // see RULE14
        `MIP_IDX_CTRL: ctrl_reg                    <= wr_data & `MIP_MSK_CTRL;
        default: begin
          // Unmapped and read-only indexes store nothing.
        end
      endcase
    end
  end

  // Write response one cycle after both halves are in; held until BREADY.
  always @(posedge CLK) begin
    if (!RSTN) begin
      BVALID <= 1'b0;
      BRESP  <= `MIP_RESP_OKAY;
    end else if (wr_fire) begin
      BVALID <= 1'b1;
      BRESP  <= mapped(wr_idx) && wr_idx != `MIP_IDX_STAT ? `MIP_RESP_OKAY : `MIP_RESP_SLVERR;
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Read mux over the bank; narrow registers sit in the low byte.
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (word_idx(ARADDR))
      `MIP_IDX_HYST: rd_byte = motion_hysteresis_cfg_reg;
      `MIP_IDX_HDLY: rd_byte = highg_delay_cfg_reg;
      `MIP_IDX_HTHR: rd_byte = highg_threshold_cfg_reg;
      `MIP_IDX_DUR:  rd_byte = anymotion_duration_cfg_reg;
      `MIP_IDX_ATHR: rd_byte = anymotion_threshold_cfg_reg;
      `MIP_IDX_STHR: rd_byte = stillness_threshold_cfg_reg;
      `MIP_IDX_TAP:  rd_byte = knock_timing_cfg_reg;
      `MIP_IDX_CTRL: rd_byte = ctrl_reg;
      `MIP_IDX_STAT: rd_byte = {6'h00, still_active, any_active};
      default:       rd_byte = 8'h00;
    endcase
  end

  // Read data one cycle after the address is taken; held until RREADY.
  always @(posedge CLK) begin
    if (!RSTN) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= `MIP_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= {24'h000000, rd_byte};
      RRESP  <= mapped(word_idx(ARADDR)) ? `MIP_RESP_OKAY : `MIP_RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // Decoded timing figures, registered so every data output leaves a flip-flop.
  always @(posedge CLK) begin
    if (!RSTN) begin
      HIGHG_DELAY_MS <= 10'h000;
      LOWG_SUM_MODE  <= 1'b0;
      NOMOTION_SEC   <= 9'h000;
      TAP_QUIET_MS   <= 7'h00;
      TAP_SHOCK_MS   <= 7'h00;
      DTAP_WINDOW_MS <= 10'h000;
    end else begin
      HIGHG_DELAY_MS <= ({2'h0, highg_delay_cfg_reg} + 10'h001) * `MIP_HDLY_STEP_MS;  // see RULE4
      LOWG_SUM_MODE  <= motion_hysteresis_cfg_reg[`MIP_F_LMODE];                     // see RULE2
      NOMOTION_SEC   <= nomo_sec(anymotion_duration_cfg_reg[`MIP_F_SDUR]);           // see RULE7
      TAP_QUIET_MS   <= knock_timing_cfg_reg[`MIP_F_QUIET] ? `MIP_QUIET1_MS : `MIP_QUIET0_MS;  // see RULE11
      TAP_SHOCK_MS   <= knock_timing_cfg_reg[`MIP_F_SHOCK] ? `MIP_SHOCK1_MS : `MIP_SHOCK0_MS;  // see RULE12
      DTAP_WINDOW_MS <= tap_window(knock_timing_cfg_reg[`MIP_F_TDUR]);               // see RULE13
    end
  end

  // One-second tick for the no-motion timer; shorten SEC_CYCLES in simulation.
  always @(posedge CLK) begin
    if (!RSTN) begin
      sec_cnt_reg  <= 32'h0000_0000;
      sec_tick_reg <= 1'b0;
    end else if (sec_cnt_reg == SEC_CYCLES - 32'h0000_0001) begin
      sec_cnt_reg  <= 32'h0000_0000;
      sec_tick_reg <= 1'b1;
    end else begin
      sec_cnt_reg  <= sec_cnt_reg + 32'h0000_0001;
      sec_tick_reg <= 1'b0;
    end
  end

  // Thresholds and high-g hysteresis follow the range field one cycle later; low-g hysteresis ignores it.
  mip_scale u_scale (
    .clk                 (CLK),
    .rstn                (RSTN),
    .range_sel           (ctrl_reg[`MIP_F_RANGE]),
    .highg_hysteresis    (motion_hysteresis_cfg_reg[`MIP_F_HHYST]),
    .lowg_hysteresis     (motion_hysteresis_cfg_reg[`MIP_F_LHYST]),
    .highg_threshold     (highg_threshold_cfg_reg),
    .anymotion_threshold (anymotion_threshold_cfg_reg),
    .stillness_threshold (stillness_threshold_cfg_reg),
    .highg_thresh_out    (HIGHG_THRESH),
    .highg_hyst_out      (HIGHG_HYST),
    .lowg_hyst_out       (LOWG_HYST),
    .any_thresh_out      (ANYMOTION_THRESH),
    .still_thresh_out    (STILLNESS_THRESH)
  );

  // Any-motion is always a sample count; it never uses the second tick.
  mip_motion u_any (
    .clk           (CLK),
    .rstn          (RSTN),
    .sample_strobe (SAMPLE_STROBE),
    .slope_mag     (SLOPE_MAG),
    .thresh        (ANYMOTION_THRESH),
    .need_cnt      ({1'b0, anymotion_duration_cfg_reg[`MIP_F_ADUR]} + 3'h1),  // see RULE8
    .timed_mode    (1'b0),
    .hold_sec      (9'h000),
    .sec_tick      (1'b0),
    .trig          (ANYMOTION_TRIG),
    .active        (any_active)
  );

  // Stillness counts samples in slow-motion mode, or times quiet in no-motion mode.
  mip_motion u_still (
    .clk           (CLK),
    .rstn          (RSTN),
    .sample_strobe (SAMPLE_STROBE),
    .slope_mag     (SLOPE_MAG),
    .thresh        (STILLNESS_THRESH),
    .need_cnt      ({1'b0, anymotion_duration_cfg_reg[`MIP_F_SCNT]} + 3'h1),  // see RULE6
    .timed_mode    (ctrl_reg[`MIP_F_SSEL]),                                 // see RULE7
    .hold_sec      (NOMOTION_SEC),
    .sec_tick      (sec_tick_reg),
    .trig          (STILLNESS_TRIG),
    .active        (still_active)
  );
endmodule

// >>> test/mip_monitor.sv
// Purpose: Port-level checks of the motion parameter bank.
// Assumes: Bound to mip_param_regs; one clock, synchronous reset.
// Notes:   Derived outputs are judged only once they have had time to load after reset.
module mip_monitor (
  // Clock and reset.
  input logic        CLK,
  input logic        RSTN,
  // Bus handshakes.
  input logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, ARVALID, ARREADY, RVALID,
  // Sample path and events.
  input logic        SAMPLE_STROBE,
  input logic [11:0] SLOPE_MAG,
  input logic [11:0] ANYMOTION_THRESH,
  input logic        ANYMOTION_TRIG,
  input logic        STILLNESS_TRIG,
  // Decoded settings.
  input logic [11:0] HIGHG_HYST,
  input logic [11:0] LOWG_HYST,
  input logic [9:0]  HIGHG_DELAY_MS,
  input logic [8:0]  NOMOTION_SEC,
  input logic [6:0]  TAP_QUIET_MS,
  input logic [6:0]  TAP_SHOCK_MS,
  input logic [9:0]  DTAP_WINDOW_MS
);
  // Counts edges after reset, since the decoded outputs lag the registers.
  logic [1:0] up_reg;
  always @(posedge CLK) begin
    up_reg <= !RSTN ? 2'h0 : (up_reg == 2'h3 ? up_reg : up_reg + 2'h1);
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_hdly;
    up_reg == 2'h3 |-> !HIGHG_DELAY_MS[0] && HIGHG_DELAY_MS inside {[2:512]};
  endproperty
  a_hdly: assert property (p_hdly) else $error("high-g delay off grid");
  property p_quiet;
    up_reg == 2'h3 |-> TAP_QUIET_MS inside {7'h1E, 7'h14};
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet time illegal");
  property p_shock;
    up_reg == 2'h3 |-> TAP_SHOCK_MS inside {7'h32, 7'h4B};
  endproperty
  a_shock: assert property (p_shock) else $error("shock time illegal");
  property p_win;
    up_reg == 2'h3 |-> DTAP_WINDOW_MS inside {50, 100, 150, 200, 250, 375, 500, 700};
  endproperty
  a_win: assert property (p_win) else $error("tap window illegal");
  property p_nomo;
    up_reg == 2'h3 |-> NOMOTION_SEC inside {[1:336]};
  endproperty
  a_nomo: assert property (p_nomo) else $error("no-motion time out of span");
  property p_hhyst;
    up_reg == 2'h3 |-> HIGHG_HYST[4:0] == 5'h00;
  endproperty
  a_hhyst: assert property (p_hhyst) else $error("high-g hysteresis off grid");
  property p_lhyst;
    up_reg == 2'h3 |-> LOWG_HYST inside {12'h000, 12'h020, 12'h040, 12'h060};
  endproperty
  a_lhyst: assert property (p_lhyst) else $error("low-g hysteresis off grid");
  // A trigger must follow a strobe that lay strictly above the threshold.
  property p_any_cause;
    ANYMOTION_TRIG |-> $past(SAMPLE_STROBE) && $past(SLOPE_MAG) > $past(ANYMOTION_THRESH);
  endproperty
  a_any_cause: assert property (p_any_cause) else $error("trigger without cause");
  property p_any_once;
    ANYMOTION_TRIG |=> !ANYMOTION_TRIG;
  endproperty
  a_any_once: assert property (p_any_once) else $error("any-motion pulse too long");
  property p_still_once;
    STILLNESS_TRIG |=> !STILLNESS_TRIG;
  endproperty
  a_still_once: assert property (p_still_once) else $error("stillness pulse too long");
  property p_bresp;
    AWVALID && AWREADY && WVALID && WREADY |=> BVALID;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer late");
  property p_rresp;
    ARVALID && ARREADY |=> RVALID;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  c_any: cover property (ANYMOTION_TRIG);
  c_still: cover property (STILLNESS_TRIG);
  c_read: cover property (ARVALID && ARREADY);
endmodule

// >>> test/mip_param_regs_test.sv
// Purpose: Self-checking bench for the motion parameter bank.
// Assumes: BREADY and RREADY stay high; a short second keeps no-motion waits small.
// Notes:   Expected figures are worked out here from the field encodings.
`include "mip_defs.vh"
module mip_param_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 16; // Cycles per second, shortened for run time.
  logic CLK = 0, RSTN = 0;
  logic [7:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0;
  logic [3:0] WSTRB = 4'hF;
  logic AWVALID = 0, WVALID = 0, ARVALID = 0, BREADY = 1, RREADY = 1, SAMPLE_STROBE = 0;
  logic [11:0] SLOPE_MAG = 0;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, ANYMOTION_TRIG, STILLNESS_TRIG, LOWG_SUM_MODE;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [11:0] HIGHG_THRESH, HIGHG_HYST, LOWG_HYST, ANYMOTION_THRESH, STILLNESS_THRESH;
  wire [9:0] HIGHG_DELAY_MS, DTAP_WINDOW_MS;
  wire [8:0] NOMOTION_SEC;
  wire [6:0] TAP_QUIET_MS, TAP_SHOCK_MS;
  int error_cnt = 0, samples_checked = 0, cyc = 0, any_n = 0, still_n = 0;
  mip_param_regs #(.SEC_CYCLES(SEC)) mip_param_regs_i (.*);
  initial forever #4 CLK = ~CLK;
  // Watchdog and event counters; a hang counts as a mismatch.
  always @(posedge CLK) begin
    cyc++;
    any_n += (ANYMOTION_TRIG === 1'b1);
    still_n += (STILLNESS_TRIG === 1'b1);
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  task chk(string s, logic [31:0] g, logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge CLK);
  endtask
  // Write with address and data offered together, then wait for the answer.
  task wr(logic [7:0] a, logic [7:0] d, logic [1:0] r = `MIP_RESP_OKAY);
    AWADDR <= a; WDATA <= {24'h000000, d}; AWVALID <= 1; WVALID <= 1;
    do @(posedge CLK); while (!(AWREADY && WREADY));
    AWVALID <= 0; WVALID <= 0;
    do @(posedge CLK); while (!BVALID);
    chk("bresp", BRESP, r);
  endtask
  task rd(logic [7:0] a, logic [31:0] e, logic [1:0] r = `MIP_RESP_OKAY);
    ARADDR <= a; ARVALID <= 1;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 0;
    do @(posedge CLK); while (!RVALID);
    chk("rdata", RDATA, e);
    chk("rresp", RRESP, r);
  endtask
  task strobe(logic [11:0] m);
    SAMPLE_STROBE <= 1; SLOPE_MAG <= m;
    @(posedge CLK);
  endtask
  task t_reset;
    logic [7:0] rv [7] = '{`MIP_RST_HYST, `MIP_RST_HDLY, `MIP_RST_HTHR, `MIP_RST_DUR,
                           `MIP_RST_ATHR, `MIP_RST_STHR, `MIP_RST_TAP};
    for (int i = 0; i < 7; i++) rd(8'(8'h90 + 4 * i), {24'h0, rv[i]});
    chk("hdly", HIGHG_DELAY_MS, 10'h020);
    chk("hthr", HIGHG_THRESH, 12'h180);
    chk("hhyst", HIGHG_HYST, 12'h040);
    chk("lhyst", LOWG_HYST, 12'h020);
    chk("win", DTAP_WINDOW_MS, 10'h0FA);
    chk("nomo", NOMOTION_SEC, 9'h001);
    $display("t_reset done");
  endtask
  // Every range: scaled thresholds and high-g hysteresis follow the range now selected; low-g hysteresis stays put.
  task t_range;
    wr(8'h90, `MIP_MSK_HYST);
    rd(8'h90, {24'h0, `MIP_MSK_HYST});
    for (int r = 0; r < 4; r++) begin
      wr(8'h40, 8'(r));
      tick(1);
      chk("hhyst", HIGHG_HYST, 12'h003 << (5 + r));
      chk("lhyst", LOWG_HYST, 12'h060);
      chk("hthr", HIGHG_THRESH, 12'h0C0 << (1 + r));
      chk("athr", ANYMOTION_THRESH, 12'h014 << r);
      chk("sthr", STILLNESS_THRESH, 12'h014 << r);
    end
    chk("sum", LOWG_SUM_MODE, 1'h1);
    wr(8'h90, 8'h81); wr(8'h40, 8'h00);
    tick(1);
    chk("sum", LOWG_SUM_MODE, 1'h0);
    $display("t_range done");
  endtask
  task t_time;
    logic [9:0] win [8] = '{10'h032, 10'h064, 10'h096, 10'h0C8, 10'h0FA, 10'h177, 10'h1F4, 10'h2BC};
    logic [5:0] dc [5] = '{6'h00, 6'h0F, 6'h1F, 6'h3F, 6'h20};
    logic [8:0] ds [5] = '{9'h001, 9'h010, 9'h050, 9'h150, 9'h058};
    for (int c = 0; c < 8; c++) begin
      wr(8'hA8, {c[0], c[1], 3'h0, 3'(c)});
      tick(1);
      chk("win", DTAP_WINDOW_MS, win[c]);
      chk("quiet", TAP_QUIET_MS, c[0] ? 7'h14 : 7'h1E);
      chk("shock", TAP_SHOCK_MS, c[1] ? 7'h4B : 7'h32);
    end
    rd(8'hA8, {24'h0, `MIP_MSK_TAP});
    wr(8'h94, 8'h00); tick(1); chk("hdly", HIGHG_DELAY_MS, 10'h002);
    wr(8'h94, 8'hFF); tick(1); chk("hdly", HIGHG_DELAY_MS, 10'h200);
    for (int i = 0; i < 5; i++) begin
      wr(8'h9C, {dc[i], 2'h1});
      tick(1);
      chk("nomo", NOMOTION_SEC, ds[i]);
    end
    $display("t_time done");
  endtask
  // One-sample any-motion and two-sample slow-motion runs, an equal sample breaking the run, then no-motion timing.
  task t_motion;
    int a0, s0;
    wr(8'h9C, 8'h04); wr(8'h40, 8'h00);
    tick(1);
    a0 = any_n; s0 = still_n;
    strobe(12'h015); strobe(12'h014); strobe(12'h015); strobe(12'h015); strobe(12'h015);
    SAMPLE_STROBE <= 0;
    tick(2);
    chk("anyn", any_n - a0, 2);
    chk("slown", still_n - s0, 1);
    wr(8'h9C, 8'h04); wr(8'h40, 8'h04);
    strobe(12'h015);
    SAMPLE_STROBE <= 0;
    s0 = still_n;
    tick(14);
    chk("nomo0", still_n - s0, 0);
    tick(30);
    chk("nomo1", still_n > s0, 1);
    rd(8'h44, 32'h03);
    rd(8'hFC, 32'h0, `MIP_RESP_SLVERR);
    wr(8'h44, 8'h01, `MIP_RESP_SLVERR);
    rd(8'h40, 32'h04);
    $display("t_motion done");
  endtask
  task tally_and_finish;
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RSTN <= 1;
    @(posedge CLK);
    t_reset;
    t_range;
    t_time;
    t_motion;
    tally_and_finish;
  end
endmodule
bind mip_param_regs mip_monitor mip_monitor_i (.*);
